// [ilpc_pkg.sv]
// constants, register map and types for the interrupt latency and priority controller
package ilpc_pkg;
  // wishbone word byte addresses
  localparam logic [7:0] ILPC_ADDR_FLAG   = 8'h00;
  localparam logic [7:0] ILPC_ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ILPC_ADDR_PRIO   = 8'h08;
  localparam logic [7:0] ILPC_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ILPC_ADDR_CORE   = 8'h10;
  localparam logic [7:0] ILPC_ADDR_INTC1  = 8'h14;
  localparam logic [7:0] ILPC_ADDR_PEND   = 8'h18;
  localparam logic [7:0] ILPC_ADDR_ALT    = 8'h1c;
  localparam logic [7:0] ILPC_ADDR_SEQ    = 8'h20;
  // field positions
  localparam int ILPC_CORE_VAR_BIT   = 15;
  localparam int ILPC_CORE_MSB_BIT   = 3;
  localparam int ILPC_INTC1_NST_BIT  = 15;
  localparam int ILPC_SR_IPL_LO      = 5;
  localparam int ILPC_PEND_LVL_LO    = 8;
  localparam int ILPC_ALT_TWO_LO     = 4;
  localparam int ILPC_SEQ_LAT_LO     = 8;
  // values
  localparam logic [2:0] ILPC_IPL_ALL_MASKED = 3'h7;
  localparam logic [2:0] ILPC_MASTER_CPU     = 3'h0;
  localparam logic [3:0] ILPC_LAT_FIXED      = 4'hd;
  localparam logic [3:0] ILPC_LAT_VAR_MIN    = 4'h9;
  localparam logic [3:0] ILPC_ENTRY_CYCLES   = 4'h4;
  localparam logic [3:0] ILPC_RETURN_CYCLES  = 4'h4;
  localparam logic [31:0] ILPC_BAD_ADDR_DATA = 32'hdeadbeef;

  typedef enum logic [1:0] {
    ILPC_IDLE,
    ILPC_FINISH,
    ILPC_ENTRY,
    ILPC_RETURN
  } ilpc_state_t;
endpackage

// [ilpc_ctrl.sv]
// interrupt latency, priority and entry/return sequencing with a wishbone register slave
`timescale 1ns/100ps
// Function
// - entry latency during two-cycle instructions equals one-cycle instruction latency
// - request in second cycle of two-cycle instruction enters as one-cycle case
// - return cycles one and two pop program counter and status low byte
// - return cycle three fetches as no-op; cycle four resumes execution
// - core control bit 15 selects fixed or variable exception latency
// - fixed mode with cpu master priority gives identical latency for every instruction without an extra cycle
// - fixed mode adds one cycle for psv double move, stall, last repeat
// - variable mode with cpu master priority gives variable latency
// - fixed mode exception processing takes thirteen cycles
// - variable mode exception processing takes nine to thirteen cycles
// - current instruction completes before entry sequence starts
// - one flag per source, set by source, cleared only by software
// - one enable bit per source gates its request
// - each source holds one of eight priority levels
// - pending vector latched into 8 bits, pending level into 4 bits
// - status bits 7:5 report cpu priority and are software writable
// - priority msb in core control is read-only to software
// - alternate register sets each have a priority level field
// - code 111 means level 7 or 15, codes below map down to 0 or 8
// - cpu level is core msb concatenated above the three status bits
// - nesting disable makes status priority bits read-only
// - nesting disabled forces priority field to 111 on taking any interrupt
// - after context save pending priority is written to cpu priority field
module ilpc_ctrl
  import ilpc_pkg::*;
#(
  parameter int N_SRC = 8
) (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // wishbone slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [31:0]        i_wb_dat,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  // interrupt sources, asynchronous pulses or levels
  input  wire logic [N_SRC-1:0]   i_src,
  // cpu sequencer status
  input  wire logic               i_instr_end,
  input  wire logic               i_return_from_interrupt_instr,
  input  wire logic               i_extra_cycle,
  input  wire logic [2:0]         i_bus_master_priority,
  // cpu sequencer controls
  output logic                    o_irq_req,
  output logic                    o_entry_save,
  output logic                    o_entry_nop,
  output logic                    o_vector_load,
  output logic                    o_ret_pop,
  output logic                    o_ret_nop,
  output logic                    o_ret_resume,
  output logic      [7:0]         o_vector,
  output logic      [3:0]         o_cpu_level,
  output logic      [1:0]         o_alt_set_sel
);
  if (N_SRC < 1 || N_SRC > 8) begin : g_bad_n_src
    $error("N_SRC must be 1 to 8");
  end

  typedef struct packed {
    ilpc_state_t       state;
    logic [3:0]        cnt;
    logic [3:0]        lat;
    logic [N_SRC-1:0]  sync1;
    logic [N_SRC-1:0]  sync2;
    logic [N_SRC-1:0]  src_d;
    logic [N_SRC-1:0]  flag;
    logic [N_SRC-1:0]  enable;
    logic [N_SRC*3-1:0] prio;
    logic [2:0]        cpu_priority_level;
    logic              ipl_msb;
    logic              var_mode;
    logic              nest_dis;
    logic [7:0]        vec;
    logic [3:0]        lvl;
    logic [2:0]        alt_one;
    logic [2:0]        alt_two;
    logic [3:0]        last_lat;
    logic [2:0]        sav_ipl;
    logic              irq;
    logic              save;
    logic              nop;
    logic              vload;
    logic              pop;
    logic              rnop;
    logic              resume;
    logic [1:0]        alt_sel;
    logic [31:0]       rdat;
    logic              ack;
  } ilpc_regs_t;

  ilpc_regs_t r_reg;
  ilpc_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////////////
  // priority resolution and register access

  logic             wr;
  logic             rd_any;
  logic [N_SRC-1:0] pend;
  logic             win_v;
  logic [7:0]       win_idx;
  logic [2:0]       win_pri;
  logic [3:0]       cur_level;
  logic [31:0]      rdata;
  logic [31:0]      wmask;
  logic             hit_flag;
  logic             hit_enable;
  logic             hit_prio;
  logic             hit_status;
  logic             hit_core;
  logic             hit_intc1;
  logic             hit_pend;
  logic             hit_alt;
  logic             hit_seq;

  // one decode shared by read mux and write path, so both always agree on the map
  always_comb begin
    hit_flag   = 1'b0;
    hit_enable = 1'b0;
    hit_prio   = 1'b0;
    hit_status = 1'b0;
    hit_core   = 1'b0;
    hit_intc1  = 1'b0;
    hit_pend   = 1'b0;
    hit_alt    = 1'b0;
    hit_seq    = 1'b0;
    if (i_wb_adr == ILPC_ADDR_FLAG) begin
      hit_flag = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_ENABLE) begin
      hit_enable = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_PRIO) begin
      hit_prio = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_STATUS) begin
      hit_status = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_CORE) begin
      hit_core = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_INTC1) begin
      hit_intc1 = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_PEND) begin
      hit_pend = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_ALT) begin
      hit_alt = 1'b1;
    end else if (i_wb_adr == ILPC_ADDR_SEQ) begin
      hit_seq = 1'b1;
    end
  end

  always_comb begin
    wr        = i_wb_cyc & i_wb_stb & i_wb_we & ~r_reg.ack;
    rd_any    = i_wb_cyc & i_wb_stb & ~r_reg.ack;
    wmask     = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    cur_level = {r_reg.ipl_msb, r_reg.cpu_priority_level};
    pend      = r_reg.flag & r_reg.enable;
    win_v     = 1'b0;
    win_idx   = 8'h00;
    win_pri   = 3'h0;
    // strictly greater wins, so the lowest index keeps ties
    for (int i = 0; i < N_SRC; i++) begin
      if (pend[i] && {1'b0, r_reg.prio[i*3 +: 3]} > cur_level && (!win_v || r_reg.prio[i*3 +: 3] > win_pri)) begin
        win_v   = 1'b1;
        win_idx = 8'(i);
        win_pri = r_reg.prio[i*3 +: 3];
      end
    end
    rdata = 32'h0;
    if (hit_flag) begin
      rdata[N_SRC-1:0] = r_reg.flag;
    end else if (hit_enable) begin
      rdata[N_SRC-1:0] = r_reg.enable;
    end else if (hit_prio) begin
      rdata[N_SRC*3-1:0] = r_reg.prio;
    end else if (hit_status) begin
      rdata[ILPC_SR_IPL_LO +: 3] = r_reg.cpu_priority_level;
    end else if (hit_core) begin
      rdata[ILPC_CORE_VAR_BIT] = r_reg.var_mode;
      rdata[ILPC_CORE_MSB_BIT] = r_reg.ipl_msb;
    end else if (hit_intc1) begin
      rdata[ILPC_INTC1_NST_BIT] = r_reg.nest_dis;
    end else if (hit_pend) begin
      rdata[7:0] = r_reg.vec;
      rdata[ILPC_PEND_LVL_LO +: 4] = r_reg.lvl;
    end else if (hit_alt) begin
      rdata[2:0] = r_reg.alt_one;
      rdata[ILPC_ALT_TWO_LO +: 3] = r_reg.alt_two;
    end else if (hit_seq) begin
      rdata[3:0] = r_reg.last_lat;
      rdata[ILPC_SEQ_LAT_LO +: 2] = r_reg.state;
    end else begin
      rdata = ILPC_BAD_ADDR_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [31:0]      wval;
  logic [N_SRC-1:0] rise;

  always_comb begin
    r_next = r_reg;
    wval   = (rdata & ~wmask) | (i_wb_dat & wmask);
    rise   = r_reg.sync2 & ~r_reg.src_d;
    r_next.sync1  = i_src;
    r_next.sync2  = r_reg.sync1;
    r_next.src_d  = r_reg.sync2;
    r_next.ack    = rd_any;
    r_next.rdat   = rd_any ? rdata : 32'h0;
    r_next.save   = 1'b0;
    r_next.nop    = 1'b0;
    r_next.vload  = 1'b0;
    r_next.pop    = 1'b0;
    r_next.rnop   = 1'b0;
    r_next.resume = 1'b0;

    // register writes; the window has no stray bits so unmapped writes are dropped
    if (wr) begin
      if (hit_flag) begin
        r_next.flag = wval[N_SRC-1:0];
      end else if (hit_enable) begin
        r_next.enable = wval[N_SRC-1:0];
      end else if (hit_prio) begin
        r_next.prio = wval[N_SRC*3-1:0];
      end else if (hit_status) begin
        if (!r_reg.nest_dis) begin
          r_next.cpu_priority_level = wval[ILPC_SR_IPL_LO +: 3];
        end
      end else if (hit_core) begin
        r_next.var_mode = wval[ILPC_CORE_VAR_BIT]; // msb stays read-only
      end else if (hit_intc1) begin
        r_next.nest_dis = wval[ILPC_INTC1_NST_BIT];
      end else if (hit_alt) begin
        r_next.alt_one = wval[2:0];
        r_next.alt_two = wval[ILPC_ALT_TWO_LO +: 3];
      end
    end
    // hardware set wins over a software clear in the same cycle
    r_next.flag = r_next.flag | rise;

    // one-cycle pulse at the recognition edge; a return starting in the same cycle takes precedence
    r_next.irq = win_v & (r_reg.state == ILPC_IDLE) & ~i_return_from_interrupt_instr;
    if (win_v) begin
      r_next.vec = win_idx;
      r_next.lvl = {1'b0, win_pri};
    end

    case (r_reg.state)
      ILPC_IDLE: begin
        r_next.cnt = 4'h0;
        if (i_return_from_interrupt_instr) begin
          r_next.state = ILPC_RETURN;
          r_next.pop   = 1'b1;
          r_next.cnt   = 4'h1;
        end else if (win_v) begin
          // latency: fixed, plus one for a psv stall case; variable may shorten it
          if (!r_reg.var_mode && i_bus_master_priority == ILPC_MASTER_CPU) begin
            r_next.lat = ILPC_LAT_FIXED + {3'h0, i_extra_cycle};
          end else begin
            r_next.lat = i_extra_cycle ? ILPC_LAT_FIXED : ILPC_LAT_VAR_MIN;
          end
          // a two-cycle instruction finishes inside the first two entry cycles
          r_next.state = i_instr_end ? ILPC_ENTRY : ILPC_FINISH;
        end
      end
      ILPC_FINISH: begin
        r_next.state = ILPC_ENTRY;
        r_next.save  = 1'b1;
        r_next.cnt   = 4'h1;
      end
      ILPC_ENTRY: begin
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.cnt == 4'h0) begin
          r_next.save = 1'b1;
        end else if (r_reg.cnt == 4'h1) begin
          r_next.nop = 1'b1;
        end else if (r_reg.cnt == 4'h2) begin
          r_next.vload   = 1'b1;
          r_next.sav_ipl = r_reg.cpu_priority_level;
          // context saved: raise cpu level to the pending priority, or to 7 when nesting is disabled
          r_next.cpu_priority_level     = r_reg.nest_dis ? ILPC_IPL_ALL_MASKED : r_reg.lvl[2:0];
          r_next.alt_sel = (r_reg.lvl[2:0] == r_reg.alt_one) ? 2'h1 :
                           (r_reg.lvl[2:0] == r_reg.alt_two) ? 2'h2 : 2'h0;
        end else if (r_reg.cnt == 4'(r_reg.lat - 4'h1)) begin
          r_next.state    = ILPC_IDLE;
          r_next.last_lat = r_reg.lat;
        end
      end
      ILPC_RETURN: begin
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.cnt == 4'h1) begin
          r_next.pop = 1'b1;
          r_next.cpu_priority_level = r_reg.sav_ipl;
        end else if (r_reg.cnt == 4'h2) begin
          r_next.rnop    = 1'b1;
          r_next.alt_sel = 2'h0;
        end else if (r_reg.cnt == ILPC_RETURN_CYCLES - 4'h1) begin
          r_next.resume = 1'b1;
          r_next.state  = ILPC_IDLE;
        end
      end
      default: begin
        r_next.state = ILPC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_reg          <= '0;
      r_reg.state    <= ILPC_IDLE;
      r_reg.lat      <= ILPC_LAT_FIXED;
      r_reg.last_lat <= ILPC_LAT_FIXED;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    o_wb_dat      = r_reg.rdat;
    o_wb_ack      = r_reg.ack;
    o_irq_req     = r_reg.irq;
    o_entry_save  = r_reg.save;
    o_entry_nop   = r_reg.nop;
    o_vector_load = r_reg.vload;
    o_ret_pop     = r_reg.pop;
    o_ret_nop     = r_reg.rnop;
    o_ret_resume  = r_reg.resume;
    o_vector      = r_reg.vec;
    o_cpu_level   = {r_reg.ipl_msb, r_reg.cpu_priority_level};
    o_alt_set_sel = r_reg.alt_sel;
  end
endmodule

// [ilpc_ctrl_chk.sv]
// concurrent checks on the interrupt controller ports
`timescale 1ns/100ps
module ilpc_chk #(
  parameter int N_SRC = 8
) (
  // clock, reset and bus
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       o_wb_ack,
  // sequencer controls
  input wire logic       o_irq_req,
  input wire logic       o_entry_save,
  input wire logic       o_entry_nop,
  input wire logic       o_vector_load,
  input wire logic       o_ret_pop,
  input wire logic       o_ret_nop,
  input wire logic       o_ret_resume,
  input wire logic [7:0] o_vector,
  input wire logic [3:0] o_cpu_level
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_entry_tail;
    o_entry_nop ##1 o_vector_load;
  endsequence
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_entry_order: assert property (o_entry_save |=> s_entry_tail) else $error("entry order");
  a_save_once: assert property (o_entry_save |=> !o_entry_save) else $error("save repeated");
  a_ret_pop: assert property (o_ret_nop |-> $past(o_ret_pop)) else $error("nop without pop");
  a_ret_resume: assert property (o_ret_nop |=> o_ret_resume) else $error("resume late");
  a_busy_req: assert property (o_entry_save |-> !o_irq_req) else $error("request while busy");
  a_req_entry: assert property (o_irq_req |=> o_entry_save) else $error("save late after request");
  a_msb_low: assert property (o_cpu_level[3] == 1'b0) else $error("level msb set");
  a_vec_range: assert property (o_vector < N_SRC) else $error("vector out of range");
endmodule
bind ilpc_ctrl ilpc_chk #(.N_SRC(N_SRC)) u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_irq_req(o_irq_req), .o_entry_save(o_entry_save),
  .o_entry_nop(o_entry_nop), .o_vector_load(o_vector_load), .o_ret_pop(o_ret_pop), .o_ret_nop(o_ret_nop),
  .o_ret_resume(o_ret_resume), .o_vector(o_vector), .o_cpu_level(o_cpu_level));

// [ilpc_cpu_model.sv]
// instruction sequencer model facing the interrupt controller
`timescale 1ns/100ps
module ilpc_cpu_model (
  // clock, reset and bench controls
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_two_cycle,
  input  wire logic       i_extra,
  input  wire logic       i_ret_go,
  // to the controller
  output logic            o_instr_end,
  output logic            o_return_from_interrupt_instr,
  output logic            o_extra_cycle,
  output logic [2:0]      o_bus_master_priority
);
  logic phase_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  // two-cycle instructions end every other cycle; the controller must wait for the end
  assign o_instr_end = i_two_cycle ? phase_reg : 1'b1;
  // return only issued from idle by the bench; handlers are short so the budget stays small
  assign o_return_from_interrupt_instr = i_ret_go;
  assign o_extra_cycle = i_extra;
  assign o_bus_master_priority = 3'h0;
endmodule

// [ilpc_ctrl_tb_top.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module ilpc_ctrl_tb_top;
  import ilpc_pkg::*;
  logic i_clk = 0, i_reset = 1, cyc = 0, stb = 0, we = 0, two = 0, extra = 0, ret_go = 0;
  logic [7:0] adr = 8'h00, src = 8'h00, o_vector;
  logic [31:0] wdat = 32'h0, o_wb_dat, q;
  logic o_wb_ack, instr_end, return_from_interrupt_instr, xcyc, o_vector_load, o_ret_resume;
  logic [2:0] bmp;
  logic [3:0] o_cpu_level;
  logic [1:0] o_alt_set_sel;
  int n_mismatch = 0, tests_run = 0;
  always #5 i_clk = ~i_clk;
  ilpc_cpu_model i_cpu (.i_clk(i_clk), .i_reset(i_reset), .i_two_cycle(two), .i_extra(extra), .i_ret_go(ret_go),
    .o_instr_end(instr_end), .o_return_from_interrupt_instr(return_from_interrupt_instr), .o_extra_cycle(xcyc), .o_bus_master_priority(bmp));
  ilpc_ctrl #(.N_SRC(8)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_src(src),
    .i_instr_end(instr_end), .i_return_from_interrupt_instr(return_from_interrupt_instr), .i_extra_cycle(xcyc), .i_bus_master_priority(bmp),
    .o_irq_req(), .o_entry_save(), .o_entry_nop(), .o_vector_load(o_vector_load), .o_ret_pop(), .o_ret_nop(),
    .o_ret_resume(o_ret_resume), .o_vector(o_vector), .o_cpu_level(o_cpu_level), .o_alt_set_sel(o_alt_set_sel));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge i_clk); n++; end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    cyc <= 0; stb <= 0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    while (((k == 0) ? o_vector_load : o_ret_resume) !== 1'b1 && n < 60) begin @(posedge i_clk); n++; end
    if (n >= 60) chk(32'h1, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(0, ILPC_ADDR_STATUS, 0); chk(q, 32'h0);
    wb(0, 8'h40, 0); chk(q, ILPC_BAD_ADDR_DATA);
    wb(1, ILPC_ADDR_CORE, 32'h8008); wb(0, ILPC_ADDR_CORE, 0); chk(q, 32'h8000);
    wb(1, ILPC_ADDR_STATUS, 32'h20); wb(0, ILPC_ADDR_STATUS, 0); chk(q, 32'h20);
    wb(1, ILPC_ADDR_STATUS, 0);
    wb(1, ILPC_ADDR_ALT, 32'h5); wb(0, ILPC_ADDR_ALT, 0); chk(q, 32'h5);
    wb(1, ILPC_ADDR_PRIO, 32'h28f40); wb(0, ILPC_ADDR_PRIO, 0); chk(q, 32'h28f40);
    wb(1, ILPC_ADDR_ENABLE, 32'h24);
  endtask
  // sources 2,3,5 fire together: 3 is disabled, 5 ties with 2 and loses on index
  task automatic t_entry(input logic v, input logic x, input logic tw, input logic ns, input logic [3:0] lat);
    wb(1, ILPC_ADDR_CORE, {16'h0, v, 15'h0}); wb(1, ILPC_ADDR_INTC1, {16'h0, ns, 15'h0});
    two <= tw; extra <= x;
    if (ns) begin
      wb(1, ILPC_ADDR_STATUS, 32'h60); wb(0, ILPC_ADDR_STATUS, 0); chk(q, 32'h0);
      wb(1, ILPC_ADDR_ALT, 32'h50); wb(0, ILPC_ADDR_ALT, 0); chk(q, 32'h50);
    end
    src <= 8'h2c; repeat (4) @(posedge i_clk); src <= 8'h00;
    wait_ev(0);
    chk(o_cpu_level, ns ? 4'h7 : 4'h5);
    chk(o_alt_set_sel, ns ? 2'h2 : 2'h1);
    wb(0, ILPC_ADDR_PEND, 0); chk(q, 32'h502);
    wb(0, ILPC_ADDR_FLAG, 0); chk(q, 32'h2c);
    wb(1, ILPC_ADDR_FLAG, 0); wb(0, ILPC_ADDR_FLAG, 0); chk(q, 32'h0);
    repeat (14) @(posedge i_clk);
    wb(0, ILPC_ADDR_SEQ, 0); chk(q[3:0], lat);
    ret_go <= 1; @(posedge i_clk); ret_go <= 0;
    wait_ev(1); chk(o_cpu_level, 4'h0);
    wb(1, ILPC_ADDR_INTC1, 0); extra <= 0; two <= 0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 0;
    t_regs();
    t_entry(0, 0, 0, 0, ILPC_LAT_FIXED);
    t_entry(0, 1, 0, 0, 4'he);
    t_entry(1, 0, 0, 0, ILPC_LAT_VAR_MIN);
    t_entry(1, 1, 0, 0, ILPC_LAT_FIXED);
    t_entry(0, 0, 1, 1, ILPC_LAT_FIXED);
    test_done();
  end
  initial begin
    #200us;
    n_mismatch++;
    test_done();
  end
endmodule
